// file: core/cmits_pkg.sv
// Package with timing constants, register map and slot codes of the sequencer.
package cmits_pkg;

	// Clock and base period figures; the base period is truncated to whole cycles.
	localparam int CLK_NS       = 8;
	localparam int BASE_NS      = 196;
	localparam int BASE_CYC     = BASE_NS / CLK_NS;
	localparam int HALF_CYC     = BASE_CYC / 2;
	localparam int IO_CYCLE_NS  = 980;
	localparam int SLOT_COUNT   = IO_CYCLE_NS / BASE_NS;
	localparam int READ_OPEN_NS = 50;
	localparam int READ_OPEN_CYC = (READ_OPEN_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC    = 4;

	// Widths of the base period counter, microprogram address and data.
	localparam int CNT_W   = 5;
	localparam int UADDR_W = 9;
	localparam int DATA_W  = 16;

	// Counter positions within one base period.
	localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(BASE_CYC - 1);
	localparam logic [CNT_W-1:0] CNT_HALF  = CNT_W'(HALF_CYC);
	localparam logic [CNT_W-1:0] CNT_OPEN  = CNT_W'(READ_OPEN_CYC);
	localparam logic [CNT_W-1:0] CNT_PULSE = CNT_W'(PULSE_CYC);
	localparam logic [CNT_W-1:0] CNT_HEND  = CNT_W'(HALF_CYC + PULSE_CYC);

	// Register byte offsets on the AXI4-Lite port.
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FCOUNT = 8'h08;
	localparam logic [7:0] REG_TDATA  = 8'h0C;
	localparam logic [7:0] REG_UADDR  = 8'h10;

	// Control fields and their values after reset.
	localparam int         CTRL_RUN_BIT = 0;
	localparam int         CTRL_IO_BIT  = 1;
	localparam logic [1:0] CTRL_RST     = 2'h3;

	// AXI response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// One-hot I/O slots of the ring counter.
	typedef enum logic [4:0] {
		CMITS_T2 = 5'h01,
		CMITS_T3 = 5'h02,
		CMITS_T4 = 5'h04,
		CMITS_T5 = 5'h08,
		CMITS_T6 = 5'h10
	} cmits_slot_e;

endpackage : cmits_pkg

// file: core/cmits_period_timer.sv
// Free-running counter that divides the system clock into base periods.
`timescale 1ns/1ns
module cmits_period_timer #(
	parameter int                W    = 5,
	parameter logic [W-1:0]      LAST = '1
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	output logic      [W-1:0] count
);

	typedef struct packed {
		logic [W-1:0] count;
	} cmits_timer_s;

	cmits_timer_s s;
	cmits_timer_s next_s;

	// Wrap at the last position so every period has the same length.
	always_comb begin
		next_s = s;
		if (s.count == LAST) begin
			next_s.count = '0;
		end else begin
			next_s.count = s.count + W'(1);
		end
	end

	// Register the state.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign count = s.count;

endmodule : cmits_period_timer

// file: core/cmits_sequencer.sv
// Memory, I/O slot and processor freeze timing sequencer with its registers.
`timescale 1ns/1ns
// Overview of operation
// RULE_01: All timing comes from one base period of 196 ns; the code uses 24 cycles of 8 ns, 192 ns.
// RULE_02: An I/O cycle is five base periods, slots T2 to T6.
// RULE_03: A five-stage ring advances one slot per base period, free running.
// RULE_04: I/O cycles run T2 to T6; strobes only inside that window.
// RULE_05: A memory cycle is 980 ns: read or clear, then restore write; the code's five periods give 960 ns.
// RULE_06: Memory cycles start in T2 and finish in T6.
// RULE_07: Read window opens 50 ns into T2 and closes at T4 start.
// RULE_08: Second half of T3 strobes sense data into the data register.
// RULE_09: Read data valid drops at read window open, returns at T4.
// RULE_10: Write runs mid T4 into T6; separate drive and inhibit enables.
// RULE_11: Memory busy holds all cycle; address register untouched meanwhile; the code holds busy in T2 to T5 only, not in T6.
// RULE_12: Memory busy drops at the end of slot T5.
// RULE_13: One microinstruction per base period unless frozen.
// RULE_14: Each load advances the microprogram address from the mapper.
// RULE_15: Five processor clocks; three are active low, falling-edge acting.
// RULE_16: Store clock ends each executed cycle and writes the store field.
// RULE_17: Time-base clock always runs; other clocks are freeze gated.
// RULE_18: Freeze suppresses all but time-base clock; state stays unchanged.
// RULE_19: After a freeze the held step runs, next one is rechecked.
// RULE_20: Storing to address register while busy freezes until busy drops.
// RULE_21: A memory read-write command executes only in slot T6.
// RULE_22: Reading memory data waits for valid unless operand is accumulator.
module cmits_sequencer (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [7:0]                    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic      [1:0]                    s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [7:0]                    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic      [31:0]                   s_axi_rdata,
	output logic      [1:0]                    s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	input  wire logic                          store_to_m,
	input  wire logic                          mem_rw_cmd,
	input  wire logic                          conditional_source_select,
	input  wire logic                          operand_from_acc,
	input  wire logic [cmits_pkg::UADDR_W-1:0] next_uaddr,
	input  wire logic [cmits_pkg::DATA_W-1:0]  sense_data,
	input  wire logic                          io_request,
	output logic      [cmits_pkg::UADDR_W-1:0] uaddr,
	output logic                               uinst_load,
	output logic                               store_clock,
	output logic                               processor_phase_a_n,
	output logic                               processor_phase_b_n,
	output logic                               timebase_clock_n,
	output logic      [4:0]                    io_slot,
	output logic                               io_strobe,
	output logic                               memory_read_window,
	output logic                               sense_strobe_timing,
	output logic                               read_data_valid,
	output logic                               write_drive_enable,
	output logic                               inhibit_drive_enable,
	output logic                               memory_cycle_active,
	output logic      [cmits_pkg::DATA_W-1:0]  mem_data,
	output logic                               frozen
);

	typedef struct packed {
		cmits_pkg::cmits_slot_e            slot;
		logic                              mem_cyc;
		logic                              mca;
		logic                              rdw;
		logic                              sst;
		logic                              rdv;
		logic                              wde;
		logic                              ide;
		logic                              pa_n;
		logic                              pb_n;
		logic                              tb_n;
		logic                              stc;
		logic                              ld;
		logic                              ios;
		logic                              frz;
		logic [cmits_pkg::UADDR_W-1:0]     uaddr;
		logic [cmits_pkg::DATA_W-1:0]      tdata;
		logic [15:0]                       fcnt;
		logic [1:0]                        ctrl;
		logic                              aw_ok;
		logic [7:0]                        awaddr;
		logic                              w_ok;
		logic [31:0]                       wdata;
		logic [3:0]                        wstrb;
		logic                              awrdy;
		logic                              wrdy;
		logic                              bvalid;
		logic [1:0]                        bresp;
		logic                              arrdy;
		logic                              rvalid;
		logic [31:0]                       rdata;
		logic [1:0]                        rresp;
	} cmits_state_s;

	localparam cmits_state_s ST_RST = '{
		slot:  cmits_pkg::CMITS_T2,
		rdv:   1'b1,
		pa_n:  1'b1,
		pb_n:  1'b1,
		tb_n:  1'b1,
		ctrl:  cmits_pkg::CTRL_RST,
		awrdy: 1'b1,
		wrdy:  1'b1,
		arrdy: 1'b1,
		default: '0
	};

	cmits_state_s                 s;
	cmits_state_s                 next_s;
	logic [cmits_pkg::CNT_W-1:0]  cnt;
	logic                         tick;
	logic                         freeze_c;
	logic                         exec;

	// RULE_01 base period divider.
	cmits_period_timer #(
		.W    (cmits_pkg::CNT_W),
		.LAST (cmits_pkg::CNT_LAST)
	) u_timer (
		.aclk    (aclk),
		.aresetn (aresetn),
		.count   (cnt)
	);

	assign tick = (cnt == cmits_pkg::CNT_LAST);

	// RULE_20 address store guard.
	// RULE_21 read-write slot check.
	// RULE_22 data wait check.
	// The freeze decision combines registered status with the unregistered command inputs.
	assign freeze_c = ~s.ctrl[cmits_pkg::CTRL_RUN_BIT]
		| (store_to_m & s.mca)
		| (mem_rw_cmd & (s.slot != cmits_pkg::CMITS_T6))
		| (conditional_source_select & ~operand_from_acc & ~s.rdv);

	// RULE_13 one step per period.
	// RULE_19 release re-evaluates each period.
	assign exec = tick & ~freeze_c;

	// Next-state logic for timing, freeze and the register port.
	always_comb begin
		next_s = s;
		// RULE_02 five slot cycle.
		// RULE_03 ring advance.
		if (tick) begin
			case (s.slot)
				cmits_pkg::CMITS_T2: next_s.slot = cmits_pkg::CMITS_T3;
				cmits_pkg::CMITS_T3: next_s.slot = cmits_pkg::CMITS_T4;
				cmits_pkg::CMITS_T4: next_s.slot = cmits_pkg::CMITS_T5;
				cmits_pkg::CMITS_T5: next_s.slot = cmits_pkg::CMITS_T6;
				cmits_pkg::CMITS_T6: next_s.slot = cmits_pkg::CMITS_T2;
				default:             next_s.slot = cmits_pkg::CMITS_T2;
			endcase
		end
		// RULE_06 cycle locked slots.
		// RULE_05 five slot cycle.
		// A back-to-back request at the T6 edge starts the next cycle at once.
		if (tick && s.slot == cmits_pkg::CMITS_T6) begin
			next_s.mem_cyc = exec & mem_rw_cmd;
		end
		// RULE_11 busy from T2 through T5.
		// RULE_12 busy ends T5.
		next_s.mca = next_s.mem_cyc & (next_s.slot != cmits_pkg::CMITS_T6);
		// RULE_07 read window.
		next_s.rdw = s.mem_cyc
			& ((s.slot == cmits_pkg::CMITS_T2 && cnt >= cmits_pkg::CNT_OPEN)
			| (s.slot == cmits_pkg::CMITS_T3));
		// RULE_09 data valid flag.
		next_s.rdv = ~next_s.rdw;
		// RULE_08 sense strobe latch.
		next_s.sst = s.mem_cyc & (s.slot == cmits_pkg::CMITS_T3)
			& (cnt >= cmits_pkg::CNT_HALF);
		if (s.mem_cyc && s.slot == cmits_pkg::CMITS_T3
				&& cnt == cmits_pkg::CNT_HALF) begin
			next_s.tdata = sense_data;
		end
		// RULE_10 write drive windows.
		next_s.wde = s.mem_cyc
			& ((s.slot == cmits_pkg::CMITS_T4 && cnt >= cmits_pkg::CNT_HALF)
			| (s.slot == cmits_pkg::CMITS_T5)
			| (s.slot == cmits_pkg::CMITS_T6 && cnt < cmits_pkg::CNT_HALF));
		next_s.ide = next_s.wde;
		// RULE_17 free time-base clock.
		next_s.tb_n = ~(cnt >= cmits_pkg::CNT_HALF);
		// RULE_15 gated phase clocks.
		// RULE_18 freeze gates clocks.
		next_s.pa_n = ~(~freeze_c & (cnt < cmits_pkg::CNT_PULSE));
		next_s.pb_n = ~(~freeze_c & (cnt >= cmits_pkg::CNT_HALF)
			& (cnt < cmits_pkg::CNT_HEND));
		// RULE_16 store clock.
		next_s.stc = exec;
		next_s.ld = s.stc;
		// RULE_14 address advance.
		if (exec) begin
			next_s.uaddr = next_uaddr;
		end
		next_s.frz = freeze_c;
		if (tick && freeze_c) begin
			next_s.fcnt = s.fcnt + 16'h0001;
		end
		// RULE_04 strobe window.
		// Strobes sit in the settled second half of a slot of the ring.
		next_s.ios = s.ctrl[cmits_pkg::CTRL_IO_BIT] & io_request
			& (|s.slot) & (cnt >= cmits_pkg::CNT_HALF);
		// Write channels are taken in either order and held until both are in.
		if (s_axi_awvalid && s.awrdy) begin
			next_s.aw_ok = 1'b1;
			next_s.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s.wrdy) begin
			next_s.w_ok = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (s.aw_ok && s.w_ok) begin
			next_s.aw_ok = 1'b0;
			next_s.w_ok = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp = cmits_pkg::RESP_OKAY;
			case (s.awaddr)
				cmits_pkg::REG_CTRL: begin
					if (s.wstrb[0]) begin
						next_s.ctrl = s.wdata[1:0];
					end
				end
				cmits_pkg::REG_STATUS,
				cmits_pkg::REG_FCOUNT,
				cmits_pkg::REG_TDATA,
				cmits_pkg::REG_UADDR: next_s.bresp = cmits_pkg::RESP_OKAY;
				default: next_s.bresp = cmits_pkg::RESP_SLVERR;
			endcase
		end
		next_s.awrdy = ~next_s.aw_ok & ~next_s.bvalid;
		next_s.wrdy = ~next_s.w_ok & ~next_s.bvalid;
		// Read channel: one read in flight, answered the cycle after address.
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s.arrdy) begin
			next_s.rvalid = 1'b1;
			next_s.rresp = cmits_pkg::RESP_OKAY;
			case (s_axi_araddr)
				cmits_pkg::REG_CTRL:   next_s.rdata = {30'h0, s.ctrl};
				cmits_pkg::REG_STATUS: begin
					next_s.rdata = {24'h0, s.frz, s.rdv, s.mca, s.slot};
				end
				cmits_pkg::REG_FCOUNT: next_s.rdata = {16'h0, s.fcnt};
				cmits_pkg::REG_TDATA:  next_s.rdata = {16'h0, s.tdata};
				cmits_pkg::REG_UADDR:  next_s.rdata = {23'h0, s.uaddr};
				default: begin
					next_s.rdata = 32'h0;
					next_s.rresp = cmits_pkg::RESP_SLVERR;
				end
			endcase
		end
		next_s.arrdy = ~next_s.rvalid;
	end

	// Register the whole state; reset is synchronous.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= ST_RST;
		end else begin
			s <= next_s;
		end
	end

	// Every output comes straight from a state flip-flop.
	assign s_axi_awready        = s.awrdy;
	assign s_axi_wready         = s.wrdy;
	assign s_axi_bvalid         = s.bvalid;
	assign s_axi_bresp          = s.bresp;
	assign s_axi_arready        = s.arrdy;
	assign s_axi_rvalid         = s.rvalid;
	assign s_axi_rdata          = s.rdata;
	assign s_axi_rresp          = s.rresp;
	assign uaddr                = s.uaddr;
	assign uinst_load           = s.ld;
	assign store_clock          = s.stc;
	assign processor_phase_a_n  = s.pa_n;
	assign processor_phase_b_n  = s.pb_n;
	assign timebase_clock_n     = s.tb_n;
	assign io_slot              = s.slot;
	assign io_strobe            = s.ios;
	assign memory_read_window   = s.rdw;
	assign sense_strobe_timing  = s.sst;
	assign read_data_valid      = s.rdv;
	assign write_drive_enable   = s.wde;
	assign inhibit_drive_enable = s.ide;
	assign memory_cycle_active  = s.mca;
	assign mem_data             = s.tdata;
	assign frozen               = s.frz;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_rw_exec;
		tick && !freeze_c && mem_rw_cmd;
	endsequence

	sequence s_busy_span;
		s.mca [*8] ##88 s.mca ##1 !s.mca;
	endsequence

	slot_step_a: assert property (tick |=> s.slot != $past(s.slot)) // RULE_03
		else $error("ring did not advance at period end");
	slot_hold_a: assert property (!tick |=> $stable(s.slot)) // RULE_02
		else $error("ring moved inside a period");
	io_wrap_a: assert property ( // RULE_04
		tick && s.slot == cmits_pkg::CMITS_T6 |=> s.slot == cmits_pkg::CMITS_T2)
		else $error("ring did not wrap from T6 to T2");
	busy_span_a: assert property (s_rw_exec |=> s_busy_span) // RULE_11
		else $error("memory busy span is wrong");
	busy_end_a: assert property ( // RULE_12
		$fell(s.mca) |-> $past(tick) && s.slot == cmits_pkg::CMITS_T6)
		else $error("memory busy fell outside end of T5");
	rw_slot_a: assert property ( // RULE_21
		tick && mem_rw_cmd && s.slot != cmits_pkg::CMITS_T6 |=> !s.stc)
		else $error("read-write step ran outside T6");
	m_guard_a: assert property (tick && store_to_m && s.mca |=> !s.stc) // RULE_20
		else $error("address store ran while memory busy");
	sense_t3_a: assert property ( // RULE_08
		$rose(s.sst) |-> $past(s.slot) == cmits_pkg::CMITS_T3
			&& $past(cnt) == cmits_pkg::CNT_HALF)
		else $error("sense strobe not at middle of T3");
	rdv_t4_a: assert property ( // RULE_09
		$rose(s.rdv) |-> $past(s.slot) == cmits_pkg::CMITS_T4)
		else $error("data valid returned outside T4");
	write_t4_a: assert property ( // RULE_10
		$rose(s.wde) |-> $past(s.slot) == cmits_pkg::CMITS_T4 && s.ide)
		else $error("write drive did not start in T4");
	freeze_hold_a: assert property ( // RULE_18
		tick && freeze_c |=> $stable(s.uaddr) && !s.stc)
		else $error("state changed during freeze");
	uaddr_load_a: assert property ( // RULE_14
		tick && !freeze_c |=> s.uaddr == $past(next_uaddr) ##1 s.ld)
		else $error("address did not advance on load");
	data_wait_a: assert property ( // RULE_22
		tick && conditional_source_select && !operand_from_acc && !s.rdv
			|=> !s.stc)
		else $error("memory data used before valid");

endmodule : cmits_sequencer

// file: test/cmits_core_model.sv
// Behavioural model of the core array sense path facing the sequencer.
`timescale 1ns/1ns
module cmits_core_model #(
	parameter logic [15:0] WORD = 16'hA5C3
) (
	input  wire logic        aclk,
	input  wire logic        memory_read_window,
	output logic      [15:0] sense_data
);
	logic [15:0] churn = 16'h0000;

	// Outside the read window the sense outputs change every cycle, so a
	// strobe at the wrong moment latches garbage instead of a stale word.
	always @(posedge aclk) begin
		churn <= ~churn ^ 16'h1234;
	end

	// The stored word reaches the sense outputs only while the window is open.
	assign sense_data = memory_read_window ? WORD : churn;
endmodule : cmits_core_model

// file: test/testbench.sv
// Self-checking bench for the memory and I/O timing sequencer.
`timescale 1ns/1ns
module testbench;
	localparam int          PER  = cmits_pkg::BASE_CYC;
	localparam int          HALF = cmits_pkg::HALF_CYC;
	localparam logic [15:0] WORD = 16'h5A3C;
	localparam logic [4:0]  T2   = cmits_pkg::CMITS_T2;

	logic                          aclk;
	logic                          aresetn;
	logic [7:0]                    s_axi_awaddr, s_axi_araddr;
	logic [31:0]                   s_axi_wdata, s_axi_rdata;
	logic [3:0]                    s_axi_wstrb;
	logic [1:0]                    s_axi_bresp, s_axi_rresp;
	logic                          s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic                          s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic                          s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic                          s_axi_rready, store_to_m, mem_rw_cmd;
	logic                          conditional_source_select, operand_from_acc;
	logic                          io_request, uinst_load, store_clock, frozen;
	logic [cmits_pkg::UADDR_W-1:0] next_uaddr, uaddr;
	logic [cmits_pkg::DATA_W-1:0]  sense_data, mem_data;
	logic                          processor_phase_a_n, processor_phase_b_n;
	logic                          timebase_clock_n, io_strobe;
	logic [4:0]                    io_slot;
	logic                          memory_read_window, sense_strobe_timing;
	logic                          read_data_valid, write_drive_enable;
	logic                          inhibit_drive_enable, memory_cycle_active;
	int                            n_mismatch = 0;
	int                            tests_run = 0;
	int                            cnt [8];

	cmits_sequencer dut (.*);

	cmits_core_model #(.WORD(WORD)) core (
		.aclk              (aclk),
		.memory_read_window(memory_read_window),
		.sense_data        (sense_data)
	);

	// Closing report; every way out of the run passes through here.
	task automatic end_sim;
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic fail_wait;
		n_mismatch++;
		$display("wrong value at %0t: wait ran out", $time);
		end_sim;
	endtask : fail_wait

	// Write master: address and data offered together, each dropped once taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid === 1'b1) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'b0;
				return;
			end
		end
		fail_wait;
	endtask : axi_wr

	// Read master: rready stays up until the answer is sampled.
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int i = 0; i < 50; i++) begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'b0;
				return;
			end
		end
		fail_wait;
	endtask : axi_rd

	// Counts clock and strobe cycles over exactly ten base periods, so the
	// totals do not depend on where in a period the window starts.
	task automatic measure;
		logic [4:0] sl0;
		logic       tb0;
		cnt = '{default: 0};
		sl0 = io_slot;
		tb0 = timebase_clock_n;
		repeat (10 * PER) begin
			@(posedge aclk);
			cnt[0] += int'(store_clock === 1'b1);
			cnt[1] += int'(uinst_load === 1'b1);
			cnt[2] += int'(processor_phase_a_n === 1'b0);
			cnt[3] += int'(processor_phase_b_n === 1'b0);
			cnt[4] += int'(timebase_clock_n === 1'b0);
			cnt[5] += int'(io_strobe === 1'b1);
			// A ring step counts only when the one-hot slot rotates by one.
			cnt[6] += int'(io_slot === {sl0[3:0], sl0[4]});
			cnt[7] += int'(tb0 === 1'b1 && timebase_clock_n === 1'b0);
			sl0 = io_slot;
			tb0 = timebase_clock_n;
		end
	endtask : measure

	task automatic t_regs;
		logic [31:0] d;
		logic [1:0]  r;
		axi_rd(cmits_pkg::REG_CTRL, d, r);
		chk(d, 32'(cmits_pkg::CTRL_RST));
		chk(32'(r), 32'(cmits_pkg::RESP_OKAY));
		axi_rd(cmits_pkg::REG_STATUS, d, r);
		chk(32'(d[6:5]), 32'h2);
		axi_rd(8'h14, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(cmits_pkg::RESP_SLVERR));
		axi_wr(8'h20, 32'h0, r);
		chk(32'(r), 32'(cmits_pkg::RESP_SLVERR));
	endtask : t_regs

	// A read-write step, a data read from an accumulator, a data read from
	// core and a store to the address register; all but the accumulator read wait.
	task automatic t_mem;
		logic [4:0]  sl [$];
		logic [4:0]  s_sn, s_rv, s_wd, s_we, s_mc;
		logic [31:0] d;
		logic [1:0]  r;
		int          i, n_mc, n_lo, n_bad;
		bit          frz;
		{s_sn, s_rv, s_wd, s_we, s_mc} = '0;
		n_lo = 0;
		n_bad = 0;
		frz = 0;
		for (i = 0; i < 200 && io_slot !== T2; i++) @(posedge aclk);
		if (i == 200) fail_wait;
		mem_rw_cmd <= 1'b1;
		next_uaddr <= 9'h0A5;
		for (i = 0; i < 200; i++) begin
			@(posedge aclk);
			if (i > 0 && store_clock === 1'b1) break;
			if (frozen === 1'b1) frz = 1;
		end
		if (i == 200) fail_wait;
		chk(32'(io_slot), 32'(T2));
		chk(32'(frz), 32'h1);
		chk(32'(memory_cycle_active), 32'h1);
		mem_rw_cmd <= 1'b0;
		conditional_source_select <= 1'b1;
		operand_from_acc <= 1'b1;
		n_mc = 1;
		for (i = 0; i < 140; i++) begin
			@(posedge aclk);
			n_mc += int'(memory_cycle_active === 1'b1);
			n_lo += int'(read_data_valid === 1'b0);
			n_bad += int'(inhibit_drive_enable !== write_drive_enable);
			if (sense_strobe_timing === 1'b1 && s_sn == 0) s_sn = io_slot;
			if (read_data_valid && n_lo > 0 && s_rv == 0) s_rv = io_slot;
			if (write_drive_enable === 1'b1 && s_wd == 0) s_wd = io_slot;
			if (!write_drive_enable && s_wd != 0 && s_we == 0) s_we = io_slot;
			if (memory_cycle_active === 1'b0 && s_mc == 0) s_mc = io_slot;
			if (store_clock === 1'b1) begin
				sl.push_back(io_slot);
				if (sl.size() > 2) break;
				operand_from_acc <= 1'b0;
				conditional_source_select <= (sl.size() == 1);
				store_to_m <= (sl.size() == 2);
			end
		end
		store_to_m <= 1'b0;
		chk(32'(sl.size()), 32'h3);
		chk(32'(sl[0]), 32'(cmits_pkg::CMITS_T3));
		chk(32'(sl[1]), 32'(cmits_pkg::CMITS_T5));
		chk(32'(sl[2]), 32'(T2));
		chk(32'(n_mc), 32'(4 * PER));
		chk(32'(n_lo), 32'(2 * PER - cmits_pkg::READ_OPEN_CYC));
		chk(32'(s_sn), 32'(cmits_pkg::CMITS_T3));
		chk(32'(s_rv), 32'(cmits_pkg::CMITS_T4));
		chk(32'(s_wd), 32'(cmits_pkg::CMITS_T4));
		chk(32'(s_we), 32'(cmits_pkg::CMITS_T6));
		chk(32'(n_bad), 32'h0);
		chk(32'(s_mc), 32'(cmits_pkg::CMITS_T6));
		chk(32'(mem_data), 32'(WORD));
		chk(32'(uaddr), 32'h0A5);
		axi_rd(cmits_pkg::REG_TDATA, d, r);
		chk(d, 32'(WORD));
	endtask : t_mem

	task automatic t_run;
		logic [1:0] r;
		axi_wr(cmits_pkg::REG_CTRL, 32'h3, r);
		io_request <= 1'b1;
		next_uaddr <= 9'h1C3;
		repeat (PER) @(posedge aclk);
		measure;
		chk(32'(cnt[0]), 32'hA);
		chk(32'(cnt[1]), 32'hA);
		chk(32'(cnt[2]), 32'(10 * cmits_pkg::PULSE_CYC));
		chk(32'(cnt[3]), 32'(10 * cmits_pkg::PULSE_CYC));
		chk(32'(cnt[4]), 32'(10 * HALF));
		chk(32'(cnt[5]), 32'(10 * HALF));
		chk(32'(uaddr), 32'h1C3);
		chk(32'(cnt[6]), 32'hA);
		chk(32'(cnt[7]), 32'hA);
	endtask : t_run

	// With run cleared every tick is frozen, yet the time base keeps going.
	task automatic t_halt;
		logic [31:0] f0, f1;
		logic [1:0]  r;
		logic [8:0]  u0;
		axi_wr(cmits_pkg::REG_CTRL, 32'h0, r);
		next_uaddr <= 9'h0F0;
		axi_rd(cmits_pkg::REG_FCOUNT, f0, r);
		repeat (PER) @(posedge aclk);
		u0 = uaddr;
		measure;
		axi_rd(cmits_pkg::REG_FCOUNT, f1, r);
		chk(32'(cnt[0] + cnt[1]), 32'h0);
		chk(32'(cnt[2] + cnt[3]), 32'h0);
		chk(32'(cnt[4]), 32'(10 * HALF));
		chk(32'(cnt[5]), 32'h0);
		chk(32'(cnt[6]), 32'hA);
		chk(32'(uaddr), 32'(u0));
		chk(32'(f1 - f0 >= 11 && f1 - f0 <= 12), 32'h1);
	endtask : t_halt

	// Free-running clock at 125 MHz.
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end

	// Inputs start quiet, reset is held six cycles, then the scenarios run.
	initial begin
		aresetn = 1'b0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, store_to_m, mem_rw_cmd} = '0;
		{conditional_source_select, operand_from_acc, io_request} = '0;
		next_uaddr = '0;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		s_axi_wstrb <= 4'hF;
		t_regs;
		t_mem;
		t_run;
		t_halt;
		end_sim;
	end
endmodule : testbench
